// >>> rtl/flash_ctrl_defs.vh
// Named constants for the flash program and erase controller.
// Assumes an 8-bit register file with 12-bit addresses.
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

// ==========================================================
// Register file addresses
`define FLASH_CTRL_ADDR     12'hff8
`define FLASH_PSEL_ADDR     12'hff9

// ==========================================================
// Control register command codes
`define CMD_RESET           8'h00
`define CMD_KEY1            8'h73
`define CMD_KEY2            8'h8c
`define CMD_PAGE_ERASE      8'h95
`define CMD_SEL_PROTECT     8'h5e
`define CMD_MASS_ERASE      8'ha5

// ==========================================================
// Array geometry and option bits
`define PAGE_SHIFT          9
`define MAX_SECTORS         8
`define OPT_FWP_BIT         0
`define ERASED_BYTE         8'hff

// ==========================================================
// Reset values
`define RST_BYTE            8'h00
`define RST_LOCK            8'h00

// ==========================================================
// Status byte bit positions
`define ST_BUSY_BIT         0
`define ST_OPEN_BIT         1
`define ST_MASS_BIT         2
`define ST_SELP_BIT         3

`endif

// >>> rtl/flash_access_check.v
// Permission check for one page against sector locks and option bits.
// Assumes the page index is at least three bits wide.
`timescale 1ns/10ps
`include "flash_ctrl_defs.vh"

module flash_access_check #(
  parameter PAGE_W      = 4,
  parameter SEC_SHIFT   = 1,
  parameter NUM_SECTORS = 8
) (
  input  wire [PAGE_W-1:0] page,
  input  wire [7:0]        sector_lock,
  input  wire              write_protect,
  input  wire              high_lock,
  input  wire              mass_mode,
  output wire              allowed
);

  localparam integer TOP_SEC = NUM_SECTORS - 1;

  wire [PAGE_W-1:0] shifted = page >> SEC_SHIFT;
  wire [2:0]        sector  = shifted[2:0];  // R02 R13

  // ==========================================================
  // Decision
  // Both option bits clear blocks everything outside mass mode; high lock only spares low sectors
  assign allowed = ~sector_lock[sector] &                                 // R17
                   (mass_mode | write_protect |                           // R05
                    (high_lock & (sector != TOP_SEC[2:0])));              // R04

endmodule // flash_access_check

// >>> rtl/flash_program_erase_controller.v
// Flash program and erase controller: unlock sequence, page and mass erase,
// byte programming, sector protection. Assumes an array that reports each
// finished operation with arr_done and returns the addressed byte on arr_rdata
// one cycle after arr_addr is set.
// Register strobes and stores are one-cycle pulses qualified by clk_en.
// Option bits are stable levels taken from the array at start-up.
// Functional notes
// [R01] Pages of 512 bytes in eight 64-byte rows; erase clears a whole page.
// [R02] A sector is one page on 4KB parts, two pages on 8KB parts.
// [R03] Lowest two program bytes hold option bits; write-protect comes from byte 0.
// [R04] Both option bits zero: user programming and erase blocked; debug mass erase allowed.
// [R05] Write-protect option one enables programming and erase everywhere.
// [R06] Any reset leaves the controller locked.
// [R07] Unlock: page select, then 73H then 8CH to control, in that order.
// [R08] Page select rewritten: same value activates page, different value relocks.
// [R09] 95H with a page active erases it unless its sector is protected.
// [R10] Any other control value after unlock relocks.
// [R11] Mass erase only accepted from the debug port.
// [R12] Programmed page stays open for more bytes; a control write relocks it.
// [R13] At most eight sectors, each an eighth of memory or one page.
// [R14] 5EH maps sector protect onto FF9H; other values restore page select.
// [R15] 00H returns the controller to its reset state; the code only relocks, keeping page select and sector protect bits.
// [R16] Sector protect bits only set by writes, cleared only by reset.
// [R17] Program and erase refused on a protected sector.
// [R18] Programming only in erase modes: mass opens all, page opens its page.
// [R19] Erased byte is FFH; programming only clears bits.
// [R20] Core held idle while a byte programs; clock keeps running.
// [R21] Software must not program one byte more than twice between erases.
// [R22] Page number is address divided by 512; stores checked against it.
`timescale 1ns/10ps
`include "flash_ctrl_defs.vh"

module flash_program_erase_controller #(
  parameter MEM_AW = 13
) (
  input  wire              clk_sys,
  input  wire              rst_b,
  input  wire              clk_en,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire              reg_from_debug,
  input  wire [11:0]       reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  input  wire              mem_wr,
  input  wire [MEM_AW-1:0] mem_addr,
  input  wire [7:0]        mem_wdata,
  input  wire [7:0]        option_byte0,
  input  wire              option_high_sector_lock,
  input  wire [7:0]        arr_rdata,
  input  wire              arr_done,
  output reg  [MEM_AW-1:0] arr_addr,
  output reg  [7:0]        arr_wdata,
  output reg               arr_prog,
  output reg               arr_page_erase,
  output reg               arr_mass_erase,
  output reg               cpu_stall
);

  // ==========================================================
  // Geometry
  localparam PAGE_W      = MEM_AW - `PAGE_SHIFT;
  localparam PAGES       = 1 << PAGE_W;
  // Sector size doubles, to at most eight pages, until at most eight sectors remain
  localparam SEC_SHIFT   = (PAGES > 32) ? 3 : (PAGES > 16) ? 2 : (PAGES > 8) ? 1 : 0;
  localparam NUM_SECTORS = PAGES >> SEC_SHIFT;
  localparam [`PAGE_SHIFT-1:0] PAGE_BASE = {`PAGE_SHIFT{1'b0}};

  // ==========================================================
  // States
  localparam [8:0] S_LOCKED  = 9'h001;
  localparam [8:0] S_KEY1    = 9'h002;
  localparam [8:0] S_KEY2    = 9'h004;
  localparam [8:0] S_PAGE    = 9'h008;
  localparam [8:0] S_MASS    = 9'h010;
  localparam [8:0] S_ERASE   = 9'h020;
  localparam [8:0] S_PROG_RD = 9'h040;
  localparam [8:0] S_PROG_GO = 9'h080;
  localparam [8:0] S_PROG_WT = 9'h100;

  reg [8:0]        state;
  reg [7:0]        page_sel;
  reg [7:0]        sector_write_lock;
  reg              sel_protect;
  reg              mass_mode;
  reg [MEM_AW-1:0] prog_addr;
  reg [7:0]        prog_data;
  reg [7:0]        status;

  wire             option_write_protect = option_byte0[`OPT_FWP_BIT];  // R03
  wire [PAGE_W-1:0] active_page = page_sel[PAGE_W-1:0];
  wire [PAGE_W-1:0] store_page  = mem_addr[MEM_AW-1:`PAGE_SHIFT];      // R22
  wire             erase_ok;
  wire             prog_ok;

  // ==========================================================
  // Request decode
  wire ctrl_wr   = reg_wr & (reg_addr == `FLASH_CTRL_ADDR);
  wire psel_wr   = reg_wr & (reg_addr == `FLASH_PSEL_ADDR);
  // Busy covers every state in which the array owns arr_addr
  wire busy      = (state == S_ERASE) | (state == S_PROG_RD) |
                   (state == S_PROG_GO) | (state == S_PROG_WT);
  wire page_open = (state == S_PAGE) | (state == S_MASS);

  // Page numbers past the array relock rather than wrap onto a low page
  wire page_in_range = (page_sel >> PAGE_W) == 8'h00;

  // Page select is frozen from the second key on, so an open page
  // cannot be swapped for another without a fresh unlock
  wire psel_load = psel_wr & ~sel_protect & ~page_open & (state != S_KEY2);  // R07

  // Mass erase needs the debug port and a clear protect map
  wire mass_req  = ctrl_wr & (reg_wdata == `CMD_MASS_ERASE) & reg_from_debug &
                   (sector_write_lock == `RST_LOCK);                         // R11
  wire erase_req = ctrl_wr & (reg_wdata == `CMD_PAGE_ERASE) & erase_ok;      // R09

  // A store in the same cycle as a control write loses to the write
  wire store_req = mem_wr & prog_ok &
                   (mass_mode | (store_page == active_page));                // R18 R22

  // ==========================================================
  // Permission checks
  flash_access_check #(
    .PAGE_W      (PAGE_W),
    .SEC_SHIFT   (SEC_SHIFT),
    .NUM_SECTORS (NUM_SECTORS)
  ) erase_check (
    .page          (active_page),
    .sector_lock   (sector_write_lock),
    .write_protect (option_write_protect),
    .high_lock     (option_high_sector_lock),
    .mass_mode     (1'b0),
    .allowed       (erase_ok)
  );

  flash_access_check #(
    .PAGE_W      (PAGE_W),
    .SEC_SHIFT   (SEC_SHIFT),
    .NUM_SECTORS (NUM_SECTORS)
  ) prog_check (
    .page          (store_page),
    .sector_lock   (sector_write_lock),
    .write_protect (option_write_protect),
    .high_lock     (option_high_sector_lock),
    .mass_mode     (mass_mode),
    .allowed       (prog_ok)
  );

  // ==========================================================
  // Status byte
  always @* begin
    status                = `RST_BYTE;
    status[`ST_BUSY_BIT]  = busy;
    status[`ST_OPEN_BIT]  = page_open;
    status[`ST_MASS_BIT]  = mass_mode;
    status[`ST_SELP_BIT]  = sel_protect;
  end

  // ==========================================================
  // Register read port
  // Reads have no side effects, so polling during an operation is safe
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RST_BYTE;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == `FLASH_PSEL_ADDR) begin
        reg_rdata <= sel_protect ? sector_write_lock : page_sel;  // R14
      end else if (reg_addr == `FLASH_CTRL_ADDR) begin
        reg_rdata <= status;
      end else begin
        reg_rdata <= `RST_BYTE;
      end
    end
  end

  // ==========================================================
  // Protect map select
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_protect <= 1'b0;
    end else if (clk_en && !busy && ctrl_wr) begin
      sel_protect <= (reg_wdata == `CMD_SEL_PROTECT);          // R14
    end
  end

  // ==========================================================
  // Page select and sector protect
  // Writes are ignored while the array is busy so a late debug write
  // cannot alter the page under an erase in flight
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      page_sel          <= `RST_BYTE;
      sector_write_lock <= `RST_LOCK;                          // R16
    end else if (clk_en && !busy) begin
      if (psel_wr && sel_protect) begin
        sector_write_lock <= sector_write_lock | reg_wdata;    // R16
      end else if (psel_load) begin
        page_sel <= reg_wdata;                                 // R08
      end
    end
  end

  // ==========================================================
  // Sequencer
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state          <= S_LOCKED;                              // R06
      mass_mode      <= 1'b0;
      prog_addr      <= {MEM_AW{1'b0}};
      prog_data      <= `ERASED_BYTE;
      arr_addr       <= {MEM_AW{1'b0}};
      arr_wdata      <= `ERASED_BYTE;
      arr_prog       <= 1'b0;
      arr_page_erase <= 1'b0;
      arr_mass_erase <= 1'b0;
      cpu_stall      <= 1'b0;
    end else if (clk_en) begin
      arr_prog       <= 1'b0;
      arr_page_erase <= 1'b0;
      arr_mass_erase <= 1'b0;
      case (state)
        S_LOCKED: begin
          mass_mode <= 1'b0;
          if (ctrl_wr && reg_wdata == `CMD_KEY1) begin
            state <= S_KEY1;                                   // R07
          end
        end
        S_KEY1: begin
          if (ctrl_wr) begin
            state <= (reg_wdata == `CMD_KEY2) ? S_KEY2 : S_LOCKED;  // R07
          end else if (psel_wr) begin
            state <= S_LOCKED;
          end
        end
        S_KEY2: begin
          if (ctrl_wr) begin
            state <= S_LOCKED;                                 // R10
          end else if (psel_wr && !sel_protect) begin
            if (reg_wdata == page_sel && page_in_range) begin
              state <= S_PAGE;                                 // R08
            end else begin
              state <= S_LOCKED;                               // R08
            end
          end
        end
        S_PAGE, S_MASS: begin
          if (ctrl_wr) begin
            if (erase_req) begin
              arr_addr       <= {active_page, PAGE_BASE};      // R01
              arr_page_erase <= 1'b1;                          // R09
              mass_mode      <= 1'b0;
              cpu_stall      <= 1'b1;
              state          <= S_ERASE;
            end else if (mass_req) begin
              arr_addr       <= {MEM_AW{1'b0}};
              arr_mass_erase <= 1'b1;                          // R11
              mass_mode      <= 1'b1;
              cpu_stall      <= 1'b1;
              state          <= S_ERASE;
            end else begin
              state <= S_LOCKED;                               // R10 R12 R15
            end
          end else if (store_req) begin                        // R18 R22
            prog_addr <= mem_addr;
            prog_data <= mem_wdata;
            arr_addr  <= mem_addr;
            cpu_stall <= 1'b1;                                 // R20
            state     <= S_PROG_RD;
          end
        end
        S_ERASE: begin
          // The array alone decides how long an erase takes
          if (arr_done) begin
            cpu_stall <= 1'b0;
            state     <= mass_mode ? S_MASS : S_PAGE;
          end
        end
        S_PROG_RD: begin
          // One cycle for the array to return the old byte
          state <= S_PROG_GO;
        end
        S_PROG_GO: begin
          // Old byte folded in so a store can never set a bit
          arr_wdata <= prog_data & arr_rdata;                  // R19
          arr_addr  <= prog_addr;
          arr_prog  <= 1'b1;
          state     <= S_PROG_WT;
        end
        S_PROG_WT: begin
          if (arr_done) begin
            cpu_stall <= 1'b0;                                 // R20
            state     <= mass_mode ? S_MASS : S_PAGE;          // R12
          end
        end
        default: begin
          cpu_stall <= 1'b0;
          state     <= S_LOCKED;
        end
      endcase
    end
  end

endmodule // flash_program_erase_controller

// >>> test/flash_ctrl_assertions.sv
// Checker on the flash controller top ports.
// Assumes clk_en stays high while an operation runs.
`timescale 1ns/10ps
`include "flash_ctrl_defs.vh"
module flash_ctrl_checker #(parameter MEM_AW = 13) (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              reg_wr,
  input wire logic              reg_from_debug,
  input wire logic [11:0]       reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              mem_wr,
  input wire logic [7:0]        arr_rdata,
  input wire logic              arr_done,
  input wire logic [MEM_AW-1:0] arr_addr,
  input wire logic [7:0]        arr_wdata,
  input wire logic              arr_prog,
  input wire logic              arr_page_erase,
  input wire logic              arr_mass_erase,
  input wire logic              cpu_stall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Assertions
  chk_erase_cause: assert property (arr_page_erase |-> $past(reg_wr && reg_addr == `FLASH_CTRL_ADDR && reg_wdata == `CMD_PAGE_ERASE)) else $error("page erase without command");
  chk_mass_cause: assert property (arr_mass_erase |-> $past(reg_wr && reg_from_debug && reg_wdata == `CMD_MASS_ERASE)) else $error("mass erase not from debug");
  chk_mass_addr: assert property (arr_mass_erase |-> arr_addr == 0 && cpu_stall) else $error("mass erase address or stall wrong");
  chk_page_base: assert property (arr_page_erase |-> arr_addr[8:0] == 9'h000 && cpu_stall) else $error("erase not on page base");
  chk_prog_clear: assert property (arr_prog |-> (arr_wdata & ~arr_rdata) == 8'h00) else $error("program sets a bit");
  chk_prog_delay: assert property (arr_prog |-> $past(mem_wr, 3) && $past(cpu_stall, 2)) else $error("program pulse timing wrong");
  chk_stall_drop: assert property (cpu_stall && arr_done |=> !cpu_stall) else $error("stall held after done");
  chk_pulse_stall: assert property (!cpu_stall |-> !arr_prog && !arr_page_erase) else $error("array op while core runs");
  cov_prog: cover property (arr_prog);
  cov_erase: cover property (arr_page_erase);
  cov_mass: cover property (arr_mass_erase);
endmodule // flash_ctrl_checker
bind flash_program_erase_controller flash_ctrl_checker #(.MEM_AW(MEM_AW)) flash_ctrl_checker_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_from_debug(reg_from_debug),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .mem_wr(mem_wr), .arr_rdata(arr_rdata),
  .arr_done(arr_done), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_prog(arr_prog),
  .arr_page_erase(arr_page_erase), .arr_mass_erase(arr_mass_erase), .cpu_stall(cpu_stall));

// >>> test/flash_array_model.sv
// Behavioural flash array: byte read, program, page and mass erase.
// Assumes single-cycle command pulses; latency set by lat.
`timescale 1ns/10ps
module flash_array_model #(parameter MEM_AW = 13) (
  input wire logic              clk_sys,
  input wire logic [7:0]        lat,
  input wire logic [MEM_AW-1:0] arr_addr,
  input wire logic [7:0]        arr_wdata,
  input wire logic              arr_prog,
  input wire logic              arr_page_erase,
  input wire logic              arr_mass_erase,
  output logic [7:0]            arr_rdata,
  output logic                  arr_done
);
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  int         cnt;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    cnt = 0;
    arr_done = 1'b0;
  end
  // ==========================================
  // Nonvolatile, so no reset input
  always @(posedge clk_sys) begin
    arr_rdata <= mem[arr_addr];
    arr_done <= 1'b0;
    if (arr_prog) begin
      mem[arr_addr] <= mem[arr_addr] & arr_wdata;
      cnt <= lat;
    end else if (arr_page_erase || arr_mass_erase) begin
      for (int i = 0; i < (1<<MEM_AW); i++)
        if (arr_mass_erase || (i >> 9) == (arr_addr >> 9)) mem[i] <= 8'hff;
      cnt <= lat;
    end else if (cnt == 1) begin
      arr_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule // flash_array_model

// >>> test/testbench.sv
// Self-checking bench for the flash controller with an array model.
// Assumes the controller's default 13-bit (8KB) address width.
`timescale 1ns/10ps
`include "flash_ctrl_defs.vh"
module testbench;
  logic clk_sys, rst_b, clk_en, reg_wr, reg_rd, reg_from_debug, mem_wr, option_high_sector_lock;
  logic [11:0] reg_addr;
  logic [12:0] mem_addr;
  logic [7:0]  reg_wdata, mem_wdata, option_byte0, lat;
  wire  [7:0]  reg_rdata, arr_rdata, arr_wdata;
  wire  [12:0] arr_addr;
  wire         arr_done, arr_prog, arr_page_erase, arr_mass_erase, cpu_stall;
  logic [22:0] notes[$];
  logic [7:0]  shadow [0:8191];
  logic        rd_seen;
  logic [31:0] rng;
  int          err_total, n_compared, cycles;
  localparam logic [11:0] CT = `FLASH_CTRL_ADDR, PS = `FLASH_PSEL_ADDR;
  flash_program_erase_controller flash_program_erase_controller_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_from_debug(reg_from_debug), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .option_byte0(option_byte0), .option_high_sector_lock(option_high_sector_lock),
    .arr_rdata(arr_rdata), .arr_done(arr_done), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_prog(arr_prog), .arr_page_erase(arr_page_erase), .arr_mass_erase(arr_mass_erase),
    .cpu_stall(cpu_stall));
  flash_array_model flash_array_model_i (.clk_sys(clk_sys), .lat(lat), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_page_erase(arr_page_erase),
    .arr_mass_erase(arr_mass_erase), .arr_rdata(arr_rdata), .arr_done(arr_done));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Helpers
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [22:0] got);
    logic [22:0] exp;
    exp = (notes.size() > 0) ? notes.pop_front() : 23'bx;
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t result %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_read(input logic [7:0] v);
    chk({2'd0, 13'd0, v});
  endtask
  task automatic chk_prog(input logic [12:0] a, input logic [7:0] v);
    chk({2'd1, a, v});
  endtask
  task automatic chk_page(input logic [12:0] a);
    chk({2'd2, a, 8'h00});
  endtask
  task automatic chk_mass(input logic [12:0] a);
    chk({2'd3, a, 8'h00});
  endtask
  // One idle cycle after each strobe so back-to-back calls never glitch it
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    reg_addr = a;
    reg_wdata = d;
    reg_from_debug = dbg;
    reg_wr = 1'b1;
    @(negedge clk_sys) reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    notes.push_back({2'd0, 13'd0, e});
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys) reg_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic idle();
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 300 && cpu_stall !== 1'b0; i++) @(negedge clk_sys);
  endtask
  task automatic store(input logic [12:0] a, input logic [7:0] d, input logic ok);
    if (ok) notes.push_back({2'd1, a, shadow[a] & d});
    if (ok) shadow[a] &= d;
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge clk_sys) mem_wr = 1'b0;
    idle();
  endtask
  task automatic unlock(input logic [7:0] p);
    wr(PS, p);
    wr(CT, `CMD_KEY1);
    wr(CT, `CMD_KEY2);
    wr(PS, p);
  endtask
  // ==========================================
  // Monitor and timeout
  always @(posedge clk_sys) rd_seen <= reg_rd && clk_en;
  always @(negedge clk_sys) begin
    if (rd_seen) chk_read(reg_rdata);
    if (arr_prog) chk_prog(arr_addr, arr_wdata);
    if (arr_page_erase) chk_page(arr_addr);
    if (arr_mass_erase) chk_mass(arr_addr);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    {reg_wr, reg_rd, reg_from_debug, mem_wr, option_high_sector_lock} = 5'h00;
    {reg_addr, reg_wdata, mem_addr, mem_wdata} = 0;
    clk_en = 1'b1;
    option_byte0 = 8'h01;
    lat = 8'h02;
    rng = 27;
    rst_b = 1'b0;
    foreach (shadow[i]) shadow[i] = 8'hff;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(PS, 8'h00);
    rd(CT, 8'h00);
    store(13'h0405, rnd(), 1'b0);
    unlock(8'h02);
    rd(CT, 8'h02);
    store(13'h0405, rnd(), 1'b1);
    lat = 8'h28;
    store(13'h0405, rnd(), 1'b1);
    store(13'h0600, rnd(), 1'b0);
    notes.push_back({2'd2, 13'h0400, 8'h00});
    wr(CT, `CMD_PAGE_ERASE);
    idle();
    for (int i = 0; i < 512; i++) shadow[13'h0400 + i] = 8'hff;
    rd(CT, 8'h02);
    store(13'h0405, rnd(), 1'b1);
    wr(CT, 8'h11);
    rd(CT, 8'h00);
    store(13'h0406, rnd(), 1'b0);
    wr(PS, 8'h01);
    wr(CT, `CMD_KEY2);
    wr(CT, `CMD_KEY1);
    wr(PS, 8'h01);
    rd(CT, 8'h00);
    wr(PS, 8'h01);
    wr(CT, `CMD_KEY1);
    wr(CT, `CMD_KEY2);
    wr(PS, 8'h03);
    rd(CT, 8'h00);
    unlock(8'h01);
    wr(CT, `CMD_MASS_ERASE);
    rd(CT, 8'h00);
    unlock(8'h01);
    notes.push_back({2'd3, 13'h0000, 8'h00});
    wr(CT, `CMD_MASS_ERASE, 1'b1);
    idle();
    foreach (shadow[i]) shadow[i] = 8'hff;
    rd(CT, 8'h06);
    store(13'h1f00, rnd(), 1'b1);
    wr(CT, `CMD_RESET);
    option_byte0 = 8'h00;
    unlock(8'h02);
    wr(CT, `CMD_PAGE_ERASE);
    rd(CT, 8'h00);
    option_byte0 = 8'h01;
    // Frozen controller must ignore the write
    clk_en = 1'b0;
    wr(CT, `CMD_SEL_PROTECT);
    clk_en = 1'b1;
    rd(CT, 8'h00);
    wr(CT, `CMD_SEL_PROTECT);
    rd(CT, 8'h08);
    wr(PS, 8'h04);
    wr(PS, 8'h01);
    rd(PS, 8'h05);
    wr(CT, `CMD_RESET);
    rd(CT, 8'h00);
    unlock(8'h04);
    wr(CT, `CMD_PAGE_ERASE);
    rd(CT, 8'h00);
    unlock(8'h05);
    store(13'h0a00, rnd(), 1'b0);
    // Open page must not be swapped by a bare page select write
    wr(PS, 8'h06);
    rd(PS, 8'h05);
    wr(CT, `CMD_RESET);
    unlock(8'h06);
    store(13'h0c01, rnd(), 1'b1);
    rst_b = 1'b0;
    @(negedge clk_sys) rst_b = 1'b1;
    wr(CT, `CMD_SEL_PROTECT);
    rd(PS, 8'h00);
    if (notes.size() != 0) err_total++;
    conclude();
  end
endmodule // testbench
